// File: core/sim_monitor.sv
// Status and integrity monitor: health, range flags, config checksum
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/10ps

// Contract
// - Device ok set at init busy fall
// - State corruption after init clears device ok
// - Reset seen flag set by every reset
// - Trim store corruption sets trim error
// - Config checksum mismatch sets map error
// - Host ignores map error until checksum programmed; the monitor flags any scan mismatch from reset
// - Port error bit ORs port status
// - Range bit ORs high and low flags
// - Powered down bit follows power down
// - Sleep bit ORs channel sleep bits
// - Result above upper limit sets high flag
// - Result below lower limit sets low flag
// - Host checksums 0x71 down to 0x25
// - Checksum uses the 16-bit generator
// - Checksum preset to all ones
// - Health register at 0x20, resets 0x40
// - Checksum register 0x23-0x24, RW, resets zero
// - Self test forces both check errors while a conversion is active
module sim_monitor #(
  parameter int NUM_CH   = sim_pkg::NUM_CH,
  parameter int SAMPLE_W = sim_pkg::SAMPLE_W
) (
  input  wire logic                               core_clk_i,
  input  wire logic                               rstn_i,
  input  wire logic                               ce_i,
  sim_link_if.dev                                 link,
  input  wire logic                               init_busy_i,
  input  wire logic                               state_corrupt_i,
  input  wire logic                               soft_reset_i,
  input  wire logic [15:0]                        trim_word_i,
  input  wire logic                               trim_parity_i,
  input  wire logic [7:0]                         port_status_i,
  input  wire logic                               power_down_i,
  input  wire logic [NUM_CH-1:0]                  channel_sleep_i,
  input  wire logic                               conv_active_i,
  input  wire logic                               sample_valid_i,
  input  wire logic [NUM_CH-1:0][SAMPLE_W-1:0]    sample_i,
  input  wire logic [NUM_CH-1:0][SAMPLE_W-1:0]    channel_upper_limit_i,
  input  wire logic [NUM_CH-1:0][SAMPLE_W-1:0]    channel_lower_limit_i,
  output logic [7:0]                              health_o,
  output logic                                    self_test_o
);
  logic [7:0]        cfg_q [sim_pkg::CFG_DEPTH];
  logic              ack_q;
  logic [7:0]        rdata_q;
  logic              busy_q;
  logic              init_done_q;
  logic              dev_ok_q;
  logic              rst_seen_q;
  logic              trim_err_q;
  logic              map_err_q;
  logic [NUM_CH-1:0] hi_flag_q;
  logic [NUM_CH-1:0] lo_flag_q;
  logic [15:0]       csum_ref_q;
  logic [6:0]        scan_addr_q;
  logic [15:0]       scan_crc_q;
  logic              access;
  logic              wr;
  logic              self_test;
  logic [NUM_CH-1:0] hi_hit;
  logic [NUM_CH-1:0] lo_hit;
  logic [15:0]       scan_next;
  logic [7:0]        health;
  logic [7:0]        rd_mux;

  // Access is taken once per request; the ack cycle itself is ignored
  assign access    = ce_i && link.req && !ack_q;
  assign wr        = access && link.we;
  assign self_test = cfg_q[0][sim_pkg::SELF_TEST_BIT];
  assign link.ack  = ack_q;
  assign link.rdata = rdata_q;

  function automatic logic in_cfg(input logic [6:0] a);
    return (a >= sim_pkg::CFG_FIRST) && (a <= sim_pkg::CFG_LAST);
  endfunction : in_cfg

  function automatic logic w1c(input logic [6:0] a, input logic [6:0] reg_addr, input logic bit_val);
    return (a == reg_addr) && bit_val;
  endfunction : w1c

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_range
      assign hi_hit[ch] = sample_valid_i &&
                          ($signed(sample_i[ch]) > $signed(channel_upper_limit_i[ch]));
      assign lo_hit[ch] = sample_valid_i &&
                          ($signed(sample_i[ch]) < $signed(channel_lower_limit_i[ch]));
    end
  endgenerate

  always_comb begin
    health                       = '0;
    health[sim_pkg::B_DEV_OK]    = dev_ok_q;
    health[sim_pkg::B_RST_SEEN]  = rst_seen_q;
    health[sim_pkg::B_TRIM_ERR]  = trim_err_q;
    health[sim_pkg::B_MAP_ERR]   = map_err_q;
    health[sim_pkg::B_PORT_ERR]  = |port_status_i;
    health[sim_pkg::B_RANGE]     = |{hi_flag_q, lo_flag_q};
    health[sim_pkg::B_PWR_DOWN]  = power_down_i;
    health[sim_pkg::B_SLEEP]     = |channel_sleep_i;
  end

  always_comb begin
    rd_mux = '0;
    if (in_cfg(link.addr)) begin
      rd_mux = cfg_q[7'(link.addr - sim_pkg::CFG_FIRST)];
    end else begin
      unique case (link.addr)
        sim_pkg::ADDR_HEALTH:   rd_mux = health;
        sim_pkg::ADDR_HI_FLAGS: rd_mux = 8'(hi_flag_q);
        sim_pkg::ADDR_LO_FLAGS: rd_mux = 8'(lo_flag_q);
        sim_pkg::ADDR_CSUM_LO:  rd_mux = csum_ref_q[7:0];
        sim_pkg::ADDR_CSUM_HI:  rd_mux = csum_ref_q[15:8];
        default:                rd_mux = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_q   <= 1'b0;
      rdata_q <= '0;
    end else if (ce_i) begin
      ack_q <= link.req && !ack_q;
      // Read data stands until the next read; writes leave it alone
      if (access && !link.we) begin
        rdata_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (wr && in_cfg(link.addr)) begin
      cfg_q[7'(link.addr - sim_pkg::CFG_FIRST)] <= link.wdata;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      busy_q      <= 1'b0;
      init_done_q <= 1'b0;
      dev_ok_q    <= 1'b0;
    end else if (ce_i) begin
      busy_q <= init_busy_i;
      if (busy_q && !init_busy_i && !init_done_q) begin
        init_done_q <= 1'b1;
        dev_ok_q    <= 1'b1;
      end else if (init_done_q && state_corrupt_i) begin
        dev_ok_q <= 1'b0;
      end
    end
  end

  // Hardware set beats a simultaneous write-one clear
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_seen_q <= sim_pkg::HEALTH_RST[sim_pkg::B_RST_SEEN];
      trim_err_q <= sim_pkg::HEALTH_RST[sim_pkg::B_TRIM_ERR];
      hi_flag_q  <= NUM_CH'(sim_pkg::FLAGS_RST);
      lo_flag_q  <= NUM_CH'(sim_pkg::FLAGS_RST);
    end else if (ce_i) begin
      if (soft_reset_i) begin
        rst_seen_q <= 1'b1;
      end else if (wr && w1c(link.addr, sim_pkg::ADDR_HEALTH, link.wdata[sim_pkg::B_RST_SEEN])) begin
        rst_seen_q <= 1'b0;
      end
      if ((^{trim_word_i, trim_parity_i}) || (self_test && conv_active_i)) begin
        trim_err_q <= 1'b1;
      end else if (wr && w1c(link.addr, sim_pkg::ADDR_HEALTH, link.wdata[sim_pkg::B_TRIM_ERR])) begin
        trim_err_q <= 1'b0;
      end
      hi_flag_q <= hi_hit | (hi_flag_q &
                   ~((wr && link.addr == sim_pkg::ADDR_HI_FLAGS) ? link.wdata[NUM_CH-1:0] : '0));
      lo_flag_q <= lo_hit | (lo_flag_q &
                   ~((wr && link.addr == sim_pkg::ADDR_LO_FLAGS) ? link.wdata[NUM_CH-1:0] : '0));
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      csum_ref_q <= sim_pkg::CSUM_RST;
    end else if (ce_i && wr) begin
      if (link.addr == sim_pkg::ADDR_CSUM_LO) begin
        csum_ref_q[7:0] <= link.wdata;
      end
      if (link.addr == sim_pkg::ADDR_CSUM_HI) begin
        csum_ref_q[15:8] <= link.wdata;
      end
    end
  end

  // One config byte per cycle, top address first; the walk repeats forever
  assign scan_next = sim_pkg::crc_byte(scan_crc_q, cfg_q[7'(scan_addr_q - sim_pkg::CFG_FIRST)]);

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scan_addr_q <= sim_pkg::CFG_LAST;
      scan_crc_q  <= sim_pkg::CRC_INIT;
      map_err_q   <= sim_pkg::HEALTH_RST[sim_pkg::B_MAP_ERR];
    end else if (ce_i) begin
      if (scan_addr_q == sim_pkg::CFG_FIRST) begin
        scan_addr_q <= sim_pkg::CFG_LAST;
        scan_crc_q  <= sim_pkg::CRC_INIT;
      end else begin
        scan_addr_q <= scan_addr_q - 7'h01;
        scan_crc_q  <= scan_next;
      end
      if ((scan_addr_q == sim_pkg::CFG_FIRST && scan_next != csum_ref_q) ||
          (self_test && conv_active_i)) begin
        map_err_q <= 1'b1;
      end else if (wr && w1c(link.addr, sim_pkg::ADDR_HEALTH, link.wdata[sim_pkg::B_MAP_ERR])) begin
        map_err_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      health_o    <= sim_pkg::HEALTH_RST;
      self_test_o <= 1'b0;
    end else if (ce_i) begin
      health_o    <= health;
      self_test_o <= self_test;
    end
  end
endmodule : sim_monitor

// File: core/sim_pkg.sv
// Shared constants and checksum step for the status and integrity monitor
package sim_pkg;
  localparam int          ADDR_W        = 7;
  localparam int          DATA_W        = 8;
  localparam int          NUM_CH        = 4;
  localparam int          SAMPLE_W      = 20;
  localparam int          CRC_W         = 16;

  // Device register map
  localparam logic [6:0]  ADDR_HEALTH   = 7'h20;
  localparam logic [6:0]  ADDR_HI_FLAGS = 7'h21;
  localparam logic [6:0]  ADDR_LO_FLAGS = 7'h22;
  localparam logic [6:0]  ADDR_CSUM_LO  = 7'h23;
  localparam logic [6:0]  ADDR_CSUM_HI  = 7'h24;
  localparam logic [6:0]  CFG_FIRST     = 7'h25;
  localparam logic [6:0]  CFG_LAST      = 7'h71;
  localparam int          CFG_DEPTH     = 77;
  localparam logic [6:0]  ADDR_DEV_CTRL = 7'h25;
  localparam int          SELF_TEST_BIT = 7;

  // Health register fields
  localparam int          B_DEV_OK      = 7;
  localparam int          B_RST_SEEN    = 6;
  localparam int          B_TRIM_ERR    = 5;
  localparam int          B_MAP_ERR     = 4;
  localparam int          B_PORT_ERR    = 3;
  localparam int          B_RANGE       = 2;
  localparam int          B_PWR_DOWN    = 1;
  localparam int          B_SLEEP       = 0;
  localparam logic [7:0]  HEALTH_RST    = 8'h40;
  localparam logic [7:0]  FLAGS_RST     = 8'h00;
  localparam logic [7:0]  CFG_RST       = 8'h00;
  localparam logic [15:0] CSUM_RST      = 16'h0000;

  // Checksum generator x16+x14+x13+x12+x10+x8+x6+x4+x3+x+1, preset all ones
  localparam logic [15:0] CRC_POLY      = 16'h755b;
  localparam logic [15:0] CRC_INIT      = 16'hffff;

  // Host controller Wishbone map (byte addresses)
  localparam logic [3:0]  WB_CMD        = 4'h0;
  localparam logic [3:0]  WB_STATUS     = 4'h4;
  localparam int          CMD_WDATA_LSB = 0;
  localparam int          CMD_ADDR_LSB  = 8;
  localparam int          CMD_WRITE     = 16;
  localparam int          CMD_GO        = 17;
  localparam int          CMD_CSUM      = 18;
  localparam int          ST_BUSY       = 0;
  localparam int          ST_RDATA_LSB  = 8;
  localparam int          ST_CSUM_LSB   = 16;

  // One register byte into the checksum, most significant bit first
  function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    logic        fb;
    c = crc;
    for (int i = 7; i >= 0; i--) begin
      fb = c[15] ^ data[i];
      c  = {c[14:0], 1'b0};
      if (fb) begin
        c = c ^ CRC_POLY;
      end
    end
    return c;
  endfunction : crc_byte
endpackage : sim_pkg

// File: core/sim_link_if.sv
// Register access link between host controller and monitor
`timescale 1ns/10ps
interface sim_link_if;
  logic       req;
  logic       we;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       ack;

  modport host (output req, output we, output addr, output wdata, input rdata, input ack);
  modport dev  (input req, input we, input addr, input wdata, output rdata, output ack);
endinterface : sim_link_if

// File: core/sim_host_ctrl.sv
// Host controller: Wishbone command port driving the register link
`timescale 1ns/10ps
module sim_host_ctrl (
  input  wire logic        core_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  sim_link_if.host         link
);
  typedef enum logic [2:0] {SIM_IDLE, SIM_SINGLE, SIM_SCAN, SIM_STORE_HI, SIM_STORE_LO} sim_state_t;

  sim_state_t  state_q;
  logic        req_q;
  logic        we_q;
  logic [6:0]  addr_q;
  logic [7:0]  wdata_q;
  logic [7:0]  rdata_q;
  logic [15:0] crc_q;
  logic        wb_take;
  logic        cmd_wr;
  logic        done;
  logic [15:0] crc_next;

  assign link.req   = req_q;
  assign link.we    = we_q;
  assign link.addr  = addr_q;
  assign link.wdata = wdata_q;
  assign wb_take    = ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Commands written while busy are dropped; software polls the busy bit
  assign cmd_wr     = wb_take && wb_we_i && wb_adr_i == sim_pkg::WB_CMD && (&wb_sel_i[2:0]) && state_q == SIM_IDLE;
  assign done       = req_q && link.ack;
  assign crc_next   = sim_pkg::crc_byte(crc_q, link.rdata);

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else if (ce_i) begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (wb_take && !wb_we_i) begin
        wb_dat_o <= (wb_adr_i == sim_pkg::WB_STATUS) ?
                    {crc_q, rdata_q, 7'h00, state_q != SIM_IDLE} : '0;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= SIM_IDLE;
      req_q   <= 1'b0;
      we_q    <= 1'b0;
      addr_q  <= '0;
      wdata_q <= '0;
      rdata_q <= '0;
      crc_q   <= '0;
    end else if (ce_i) begin
      unique case (state_q)
        SIM_IDLE: begin
          if (cmd_wr && wb_dat_i[sim_pkg::CMD_CSUM]) begin
            state_q <= SIM_SCAN;
            req_q   <= 1'b1;
            we_q    <= 1'b0;
            addr_q  <= sim_pkg::CFG_LAST;
            crc_q   <= sim_pkg::CRC_INIT;
          end else if (cmd_wr && wb_dat_i[sim_pkg::CMD_GO]) begin
            state_q <= SIM_SINGLE;
            req_q   <= 1'b1;
            we_q    <= wb_dat_i[sim_pkg::CMD_WRITE];
            addr_q  <= wb_dat_i[sim_pkg::CMD_ADDR_LSB +: 7];
            wdata_q <= wb_dat_i[sim_pkg::CMD_WDATA_LSB +: 8];
          end
        end
        SIM_SINGLE: begin
          if (done) begin
            req_q   <= 1'b0;
            state_q <= SIM_IDLE;
            if (!we_q) begin
              rdata_q <= link.rdata;
            end
          end
        end
        SIM_SCAN: begin
          // Request drops for one cycle between bytes so the device sees a fresh access
          if (done) begin
            req_q <= 1'b0;
            crc_q <= crc_next;
            if (addr_q == sim_pkg::CFG_FIRST) begin
              state_q <= SIM_STORE_HI;
            end else begin
              addr_q <= addr_q - 7'h01;
            end
          end else if (!req_q) begin
            req_q <= 1'b1;
          end
        end
        SIM_STORE_HI: begin
          if (done) begin
            req_q   <= 1'b0;
            state_q <= SIM_STORE_LO;
          end else if (!req_q) begin
            req_q   <= 1'b1;
            we_q    <= 1'b1;
            addr_q  <= sim_pkg::ADDR_CSUM_HI;
            wdata_q <= crc_q[15:8];
          end
        end
        SIM_STORE_LO: begin
          if (done) begin
            req_q   <= 1'b0;
            state_q <= SIM_IDLE;
          end else if (!req_q) begin
            req_q   <= 1'b1;
            addr_q  <= sim_pkg::ADDR_CSUM_LO;
            wdata_q <= crc_q[7:0];
          end
        end
      endcase
    end
  end
endmodule : sim_host_ctrl

// File: tb/sim_link_checker.sv
// Concurrent checks on the register link between host controller and monitor
`timescale 1ns/10ps
module sim_link_checker (
  input  wire logic       core_clk_i,
  input  wire logic       rstn_i,
  input  wire logic       ce_i,
  input  wire logic       req,
  input  wire logic       we,
  input  wire logic [6:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] rdata,
  input  wire logic       ack
);
  logic [15:0] csum_q;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence take_s;
    req && !ack && ce_i;
  endsequence
  sequence rd_ans_s;
    ack && !we;
  endsequence

  // Shadow of the checksum reference, rebuilt from writes seen on the link
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      csum_q <= sim_pkg::CSUM_RST;
    end else if (req && !ack && ce_i && we) begin
      if (addr == sim_pkg::ADDR_CSUM_LO) begin
        csum_q[7:0] <= wdata;
      end
      if (addr == sim_pkg::ADDR_CSUM_HI) begin
        csum_q[15:8] <= wdata;
      end
    end
  end

  reset_idle_a: assert property ($rose(rstn_i) |-> !ack && !req)
    else $error("link not idle after reset");
  ack_pulse_a: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  ack_latency_a: assert property (take_s |=> ack)
    else $error("ack missing one cycle after request");
  ack_cause_a: assert property ($rose(ack) |-> $past(req))
    else $error("ack without request");
  req_hold_a: assert property (req && !ack |=> req && $stable(addr) && $stable(we) && $stable(wdata))
    else $error("request changed before ack");
  req_drop_a: assert property (ack |=> !req)
    else $error("request held past ack");
  rdata_hold_a: assert property ($changed(rdata) |-> rd_ans_s)
    else $error("read data changed outside a read answer");
  unmapped_zero_a: assert property (rd_ans_s ##0 (addr < sim_pkg::ADDR_HEALTH || addr > sim_pkg::CFG_LAST)
    |-> rdata == 8'h00) else $error("unmapped read not zero");
  flag_rsvd_a: assert property (
    rd_ans_s ##0 (addr == sim_pkg::ADDR_HI_FLAGS || addr == sim_pkg::ADDR_LO_FLAGS) |-> rdata[7:4] == 4'h0)
    else $error("reserved flag bits set");
  csum_lo_a: assert property (rd_ans_s ##0 (addr == sim_pkg::ADDR_CSUM_LO) |-> rdata == csum_q[7:0])
    else $error("checksum low byte mismatch");
  csum_hi_a: assert property (rd_ans_s ##0 (addr == sim_pkg::ADDR_CSUM_HI) |-> rdata == csum_q[15:8])
    else $error("checksum high byte mismatch");
endmodule : sim_link_checker

// File: tb/tb_top.sv
// Self-checking bench for the host controller and monitor pair
`timescale 1ns/10ps
`define CHK(got, exp, msg) begin \
  compares++; \
  if ((got) !== (exp)) begin \
    n_errors++; \
    $display("[FAIL] %0t %s got %0h exp %0h", $time, msg, got, exp); \
  end \
end
module tb_top;
  logic             clk = 1'b0;
  logic             rstn, ce, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [3:0]       wb_adr, wb_sel, sleep, exp_hi, exp_lo, m;
  logic [31:0]      wb_dat, wb_rd, r;
  logic             init_busy, corrupt, soft_rst, trim_par, pwr_dn, conv_act, smp_vld, self_test;
  logic [15:0]      trim_word, crc;
  logic [7:0]       port_st, health, rd;
  logic [6:0]       ra;
  logic [3:0][19:0] smp, up_lim, lo_lim, s_v, u_v, l_v;
  logic [7:0]       cfg [0:127];
  int               n_errors = 0;
  int               compares = 0;

  always #4 clk = ~clk;

  sim_link_if u_sim_link_if ();
  sim_host_ctrl u_sim_host_ctrl (.core_clk_i(clk), .rstn_i(rstn), .ce_i(ce), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_rd), .wb_ack_o(wb_ack),
    .link(u_sim_link_if.host));
  sim_monitor u_sim_monitor (.core_clk_i(clk), .rstn_i(rstn), .ce_i(ce), .link(u_sim_link_if.dev),
    .init_busy_i(init_busy), .state_corrupt_i(corrupt), .soft_reset_i(soft_rst), .trim_word_i(trim_word),
    .trim_parity_i(trim_par), .port_status_i(port_st), .power_down_i(pwr_dn), .channel_sleep_i(sleep),
    .conv_active_i(conv_act), .sample_valid_i(smp_vld), .sample_i(smp), .channel_upper_limit_i(up_lim),
    .channel_lower_limit_i(lo_lim), .health_o(health), .self_test_o(self_test));
  sim_link_checker u_sim_link_checker (.core_clk_i(clk), .rstn_i(rstn), .ce_i(ce), .req(u_sim_link_if.req),
    .we(u_sim_link_if.we), .addr(u_sim_link_if.addr), .wdata(u_sim_link_if.wdata), .rdata(u_sim_link_if.rdata),
    .ack(u_sim_link_if.ack));

  task automatic end_sim();
    $display("Comparisons %0d, errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_cyc

  task automatic wb_xfer(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= w;
    wb_adr <= a;
    wb_dat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    q = wb_rd;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (n >= 50) begin
      n_errors++;
    end
  endtask : wb_xfer

  // Issue a command, then poll status until busy drops
  task automatic run_cmd(input logic [31:0] c, output logic [31:0] s);
    int n;
    wb_xfer(1'b1, sim_pkg::WB_CMD, c, s);
    n = 0;
    do begin
      wb_xfer(1'b0, sim_pkg::WB_STATUS, 32'h0, s);
      n++;
    end while (s[sim_pkg::ST_BUSY] !== 1'b0 && n < 300);
    if (n >= 300) begin
      n_errors++;
    end
  endtask : run_cmd

  task automatic link(input logic w, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [31:0] s;
    run_cmd({13'h0, 1'b0, 1'b1, w, 1'b0, a, d}, s);
    q = s[15:8];
  endtask : link

  function automatic logic [15:0] exp_crc();
    logic [15:0] c;
    logic        fb;
    c = 16'hffff;
    for (int a = 32'h71; a >= 32'h25; a--) begin
      for (int i = 7; i >= 0; i--) begin
        fb = c[15] ^ cfg[a][i];
        c = {c[14:0], 1'b0} ^ (fb ? 16'h755b : 16'h0000);
      end
    end
    return c;
  endfunction : exp_crc

  initial begin
    #(8 * 40000);
    n_errors++;
    end_sim();
  end

  initial begin
    {rstn, wb_cyc, wb_stb, wb_we, wb_adr, wb_dat, corrupt, soft_rst, trim_par, pwr_dn, conv_act, smp_vld} = '0;
    {trim_word, port_st, sleep, smp, up_lim, lo_lim} = '0;
    ce = 1'b1;
    init_busy = 1'b1;
    wb_sel = 4'hf;
    void'($urandom(66098));
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    `CHK(health, 8'h40, "health after reset")
    `CHK(self_test, 1'b0, "self test after reset")
    link(1'b1, 7'h10, 8'ha5, rd);
    for (int i = 0; i < 5; i++) begin
      ra = (i == 0) ? 7'h20 : (i == 1) ? 7'h23 : (i == 2) ? 7'h24 : (i == 3) ? 7'h10 : 7'h7f;
      link(1'b0, ra, 8'h00, rd);
      `CHK(rd, (i == 0) ? 8'h40 : 8'h00, "read after reset")
    end
    @(posedge clk);
    init_busy <= 1'b0;
    wait_cyc(4);
    `CHK(health[7], 1'b1, "device ok after init")
    for (int a = 32'h25; a <= 32'h71; a++) begin
      cfg[a] = 8'($urandom());
      if (a == 32'h25) cfg[a][7] = 1'b0;
      link(1'b1, 7'(a), cfg[a], rd);
    end
    crc = exp_crc();
    run_cmd(32'h0004_0000, r);
    `CHK(r[31:16], crc, "host checksum")
    link(1'b0, 7'h24, 8'h00, rd);
    `CHK(rd, crc[15:8], "checksum high byte")
    link(1'b0, 7'h23, 8'h00, rd);
    `CHK(rd, crc[7:0], "checksum low byte")
    link(1'b1, 7'h20, 8'h30, rd);
    wait_cyc(200);
    `CHK(health[4], 1'b0, "map error with good reference")
    link(1'b1, 7'h23, crc[7:0] ^ 8'h01, rd);
    wait_cyc(200);
    `CHK(health[4], 1'b1, "map error with bad reference")
    link(1'b1, 7'h20, 8'h00, rd);
    wait_cyc(4);
    `CHK(health[4], 1'b1, "write zero keeps flag")
    link(1'b1, 7'h23, crc[7:0], rd);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      port_st <= (i == 0) ? 8'h00 : (i == 1) ? 8'h80 : 8'($urandom());
      pwr_dn <= 1'(i);
      sleep <= (i == 0) ? 4'h0 : 4'($urandom());
      wait_cyc(4);
      `CHK(health[3], |port_st, "port error summary")
      `CHK(health[1], pwr_dn, "powered down")
      `CHK(health[0], |sleep, "sleep summary")
    end
    exp_hi = 4'h0;
    exp_lo = 4'h0;
    for (int i = 0; i < 6; i++) begin
      for (int c = 0; c < 4; c++) begin
        u_v[c] = 20'($urandom());
        s_v[c] = (i == 0) ? u_v[c] : 20'($urandom());
        l_v[c] = (i == 0) ? u_v[c] : 20'($urandom());
        if ($signed(s_v[c]) > $signed(u_v[c])) exp_hi[c] = 1'b1;
        if ($signed(s_v[c]) < $signed(l_v[c])) exp_lo[c] = 1'b1;
      end
      @(posedge clk);
      smp <= s_v;
      up_lim <= u_v;
      lo_lim <= l_v;
      smp_vld <= 1'b1;
      @(posedge clk);
      smp_vld <= 1'b0;
      link(1'b0, 7'h21, 8'h00, rd);
      `CHK(rd, {4'h0, exp_hi}, "high limit flags")
      link(1'b0, 7'h22, 8'h00, rd);
      `CHK(rd, {4'h0, exp_lo}, "low limit flags")
      `CHK(health[2], |{exp_hi, exp_lo}, "range summary")
      m = 4'($urandom());
      link(1'b1, 7'h21, {4'hf, m}, rd);
      exp_hi = exp_hi & ~m;
      m = 4'($urandom());
      link(1'b1, 7'h22, {4'hf, m}, rd);
      exp_lo = exp_lo & ~m;
    end
    @(posedge clk);
    trim_word <= 16'h0001;
    wait_cyc(4);
    `CHK(health[5], 1'b1, "trim error")
    link(1'b1, 7'h20, 8'h20, rd);
    wait_cyc(2);
    `CHK(health[5], 1'b1, "set beats clear")
    trim_par <= 1'b1;
    link(1'b1, 7'h20, 8'h20, rd);
    wait_cyc(4);
    `CHK(health[5], 1'b0, "trim error cleared")
    link(1'b1, 7'h25, cfg[32'h25] | 8'h80, rd);
    conv_act <= 1'b1;
    wait_cyc(4);
    `CHK(self_test, 1'b1, "self test control")
    `CHK(health[5:4], 2'b11, "self test errors")
    conv_act <= 1'b0;
    link(1'b1, 7'h25, cfg[32'h25], rd);
    link(1'b1, 7'h20, 8'h30, rd);
    wait_cyc(200);
    `CHK(health[5:4], 2'b00, "errors gone after self test")
    link(1'b1, 7'h20, 8'h8f, rd);
    wait_cyc(4);
    `CHK(health[7], 1'b1, "read-only bit kept")
    corrupt <= 1'b1;
    wait_cyc(4);
    corrupt <= 1'b0;
    wait_cyc(4);
    `CHK(health[7], 1'b0, "device ok lost")
    link(1'b1, 7'h20, 8'h40, rd);
    wait_cyc(4);
    `CHK(health[6], 1'b0, "reset flag cleared")
    soft_rst <= 1'b1;
    @(posedge clk);
    soft_rst <= 1'b0;
    wait_cyc(4);
    `CHK(health[6], 1'b1, "reset flag set")
    end_sim();
  end
endmodule : tb_top
